// ### core/i2c_slave_port_params.svh
// constants for the serial register port: address map, direction and bit-count values, reset values
// assumes a 100 MHz system clock and a bus clock sampled by it
`ifndef I2C_SLAVE_PORT_PARAMS_SVH
`define I2C_SLAVE_PORT_PARAMS_SVH
`define ADDR_BASE 7'h08
`define ADDR_WEIGHT_MSB 7'h09
`define ADDR_WEIGHT_MID 7'h03
`define ADDR_WEIGHT_LSB 7'h01
`define DIR_WRITE 1'b0
`define DIR_READ 1'b1
`define REG_RESET 8'h00
`define BIT_LAST 3'h7
`endif

// ### core/i2c_slave_port_pkg.sv
// types shared by the serial register port
// assumes nothing beyond the params header
package i2c_slave_port_pkg;
  // three-level select pin as seen by the pad comparators
  typedef struct packed {
    logic is_high;
    logic is_float;
  } sel_level_t;

  typedef struct packed {
    logic [7:0] index;
    logic [7:0] data;
  } reg_write_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_INDEX = 3'b011,
    ST_INDEX_ACK = 3'b100,
    ST_WDATA = 3'b101,
    ST_WDATA_ACK = 3'b110,
    ST_RDATA = 3'b111
  } bus_state_t;
endpackage

// ### core/i2c_slave_register_port.sv
// serial-bus slave that reads and writes single 8-bit registers
// assumes bus clock and data arrive asynchronously; the register store lives outside
`include "i2c_slave_port_params.svh"

// Summary of operation
// - meets high-speed bus timing and protocol
// - each select pin decodes low, float, high
// - address is 8+9*msb+3*mid+lsb
// - slave only; single write, single read
// - data line pulled low or released only
// - acknowledge own address byte
// - store and acknowledge one data byte
// - acknowledge address with read bit
// - shift out selected register contents
module i2c_slave_register_port
  import i2c_slave_port_pkg::*;
(
  input wire logic i_clk, // 100 MHz system clock
  input wire logic i_sys_rst, // synchronous reset, active high
  input wire logic i_scl, // bus clock pin
  input wire logic i_sda, // bus data pin level
  output logic o_sda, // data pin drive value, always low
  output logic o_sda_oe, // high while pulling data low
  input wire sel_level_t i_addr_sel_msb_pin, // msb select pin level
  input wire sel_level_t i_addr_sel_mid_pin, // middle select pin level
  input wire sel_level_t i_addr_sel_lsb_pin, // lsb select pin level
  input wire logic [7:0] i_rd_data, // contents of selected register
  output logic [7:0] o_rd_index, // register number to read
  output reg_write_t o_wr, // register number and data written
  output logic o_wr_stb // one-cycle write strobe
);
  logic [1:0] scl_s;
  logic [1:0] sda_s;
  logic scl_d;
  logic sda_d;
  logic [7:0] own_addr;
  logic [7:0] shreg;
  logic [2:0] bit_cnt;
  logic [7:0] index;
  logic drive_low;
  bus_state_t state;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic byte_done; // eight bits shifted in since the last ack or start
  sel_level_t sel_raw [3];
  sel_level_t sel_s1 [3];
  sel_level_t sel_s2 [3];
  logic [7:0] sel_weight [3];
  logic [7:0] sel_term [3];

  // two flops on every pin before any logic looks at it
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      scl_s <= 2'b11;
      sda_s <= 2'b11;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_s <= {scl_s[0], i_scl};
      sda_s <= {sda_s[0], i_sda};
      scl_d <= scl_s[1];
      sda_d <= sda_s[1];
    end
  end

  // edges and bus conditions; 100 MHz oversamples a 3.4 MHz bus about 29 times
  assign scl_rise = scl_s[1] & ~scl_d;
  assign scl_fall = ~scl_s[1] & scl_d;
  assign start_seen = scl_s[1] & scl_d & sda_d & ~sda_s[1];
  assign stop_seen = scl_s[1] & scl_d & ~sda_d & sda_s[1];

  // three-level strap value: low 0, floating 1, rail 2; high wins if both flags show
  function automatic logic [7:0] level_val(input sel_level_t lvl);
    level_val = lvl.is_high ? 8'h02 : (lvl.is_float ? 8'h01 : 8'h00);
  endfunction

  // gather the straps and their weights so one loop serves all three pins
  assign sel_raw[0] = i_addr_sel_lsb_pin;
  assign sel_raw[1] = i_addr_sel_mid_pin;
  assign sel_raw[2] = i_addr_sel_msb_pin;
  assign sel_weight[0] = {1'b0, `ADDR_WEIGHT_LSB};
  assign sel_weight[1] = {1'b0, `ADDR_WEIGHT_MID};
  assign sel_weight[2] = {1'b0, `ADDR_WEIGHT_MSB};

  // straps are pins too: two flops each, since a board may rewire them live
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sel
      always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
          sel_s1[gi] <= '0;
          sel_s2[gi] <= '0;
        end else begin
          sel_s1[gi] <= sel_raw[gi];
          sel_s2[gi] <= sel_s1[gi];
        end
      end
      // weighted share of this pin in the slave address
      assign sel_term[gi] = sel_weight[gi] * level_val(sel_s2[gi]);
    end
  endgenerate

  // address recomputed every cycle; a strap change lands three cycles later
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      own_addr <= {1'b0, `ADDR_BASE};
    end else begin
      own_addr <= {1'b0, `ADDR_BASE} + sel_term[0] + sel_term[1] + sel_term[2];
    end
  end

  // protocol sequencer; slave only, never generates clock or start
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state <= ST_IDLE;
      bit_cnt <= 3'h0;
      shreg <= 8'h00;
      index <= `REG_RESET;
      drive_low <= 1'b0;
      o_wr <= '0;
      o_wr_stb <= 1'b0;
      byte_done <= 1'b0;
    end else begin
      o_wr_stb <= 1'b0;
      // a start or stop overrides whatever byte was under way
      if (start_seen) begin
        state <= ST_ADDR; // repeated start lands here too
        bit_cnt <= 3'h0;
        byte_done <= 1'b0;
        drive_low <= 1'b0;
      end else if (stop_seen) begin
        state <= ST_IDLE;
        byte_done <= 1'b0;
        drive_low <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            drive_low <= 1'b0;
          end
          ST_ADDR, ST_INDEX, ST_WDATA: begin
            // the fall that closes a start has no bits behind it, so a full
            // byte is marked by a flag rather than by the wrapped counter
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_s[1]};
              bit_cnt <= bit_cnt + 3'h1;
              byte_done <= (bit_cnt == `BIT_LAST);
            end
            if (scl_fall && byte_done) begin
              byte_done <= 1'b0;
              if (state == ST_ADDR && shreg[7:1] == own_addr[6:0]) begin
                drive_low <= 1'b1;
                state <= ST_ADDR_ACK;
              end else if (state == ST_ADDR) begin
                state <= ST_IDLE;
              end else if (state == ST_INDEX) begin
                index <= shreg;
                drive_low <= 1'b1;
                state <= ST_INDEX_ACK;
              end else begin
                o_wr <= '{index: index, data: shreg};
                o_wr_stb <= 1'b1;
                drive_low <= 1'b1;
                state <= ST_WDATA_ACK;
              end
            end
          end
          ST_ADDR_ACK: begin
            // the direction bit still sits in the lsb of the shift register;
            // register contents are fetched at the very fall that ends the ack
            if (scl_fall && shreg[0] == `DIR_READ) begin
              shreg <= i_rd_data;
              drive_low <= ~i_rd_data[7];
              bit_cnt <= 3'h0;
              state <= ST_RDATA;
            end else if (scl_fall) begin
              drive_low <= 1'b0;
              state <= ST_INDEX;
            end
          end
          ST_INDEX_ACK, ST_WDATA_ACK: begin
            if (scl_fall) begin
              drive_low <= 1'b0;
              state <= ST_WDATA; // further bytes refused below
            end
          end
          ST_RDATA: begin
            // msb went out at the ack fall; each later fall moves one bit on
            // a master that stretches the clock only slows this, it never skips a bit
            if (scl_fall && bit_cnt != `BIT_LAST) begin
              shreg <= {shreg[6:0], 1'b0};
              drive_low <= ~shreg[6];
              bit_cnt <= bit_cnt + 3'h1;
            end else if (scl_fall) begin
              drive_low <= 1'b0; // release for master ack, then await stop
              state <= ST_IDLE;
            end
          end
          default: begin
            state <= ST_IDLE;
            drive_low <= 1'b0;
          end
        endcase
        // a second data byte in one write is not supported: leave it unacknowledged
        if (state == ST_WDATA_ACK && scl_fall) begin
          state <= ST_IDLE;
        end
      end
    end
  end

  // register number stays put after a transfer, so a read can follow a write
  assign o_rd_index = index;

  // open drain: value fixed low, enable carries the data; the pull-up makes the one
  assign o_sda = 1'b0;
  assign o_sda_oe = drive_low;
endmodule

// ### verification/i2c_port_monitor.sv
// checker on the register port pins
// assumes a 160 ns bus clock against a 10 ns system clock
module i2c_port_monitor
  import i2c_slave_port_pkg::*;
(
  input wire logic i_clk, // clock
  input wire logic i_sys_rst, // reset
  input wire logic i_scl, // bus clock
  input wire logic o_sda, // drive value
  input wire logic o_sda_oe, // pull low
  input wire reg_write_t o_wr, // write
  input wire logic o_wr_stb // strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // data moves only inside a low clock phase, after sync delay
  AST_DRV_LOW: assert property (o_sda_oe |-> !o_sda) else $error("drive high");
  AST_EDGE: assert property ($changed(o_sda_oe) |-> !i_scl && $past(i_scl, 6))
    else $error("edge");
  AST_ACK: assert property ($rose(o_sda_oe) |=> o_sda_oe[*8]) else $error("ack");
  AST_REL: assert property ($fell(o_sda_oe) |-> $past(o_sda_oe, 12)) else $error("rel");
  AST_PULSE: assert property (o_wr_stb |=> !o_wr_stb) else $error("pulse");
  AST_STB_ACK: assert property (o_wr_stb |-> ##[0:1] o_sda_oe) else $error("stb ack");
  AST_STB_LOW: assert property (o_wr_stb |-> !i_scl && !$past(i_scl)) else $error("stb");
  AST_WR: assert property ($changed(o_wr) |-> o_wr_stb) else $error("wr");
  cover property (o_wr_stb);
  cover property ($rose(o_sda_oe));
  cover property ($fell(o_sda_oe));
endmodule

bind i2c_slave_register_port i2c_port_monitor mon (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_scl(i_scl), .o_sda(o_sda), .o_sda_oe(o_sda_oe), .o_wr(o_wr), .o_wr_stb(o_wr_stb));

// ### verification/i2c_host_model.sv
// bus master model: drives the clock, pulls data low
// assumes a pull-up on the data wire; clock idles high
module i2c_host_model (
  output logic scl = 1'b1, // bus clock
  output logic oe = 1'b0, // pulls data low
  input wire logic sda // wire level
);
  timeunit 1ns;
  timeprecision 1ns;
  // data falls while clock high
  task start();
    oe = 1'b0;
    #40 scl = 1'b1;
    #40 oe = 1'b1;
    #40 scl = 1'b0;
    #40;
  endtask
  task stop();
    oe = 1'b1;
    #40 scl = 1'b1;
    #40 oe = 1'b0;
    #40;
  endtask
  // data kept 40 ns clear of both clock edges
  task slot(input logic b, output logic s);
    oe = !b;
    #40 scl = 1'b1;
    #40 s = sda;
    #40 scl = 1'b0;
    #40;
  endtask
  // msb first, ninth slot left to the slave
  task send(input logic [7:0] d, output logic a);
    for (int i = 7; i >= 0; i--) slot(d[i], a);
    slot(1'b1, a);
    a = !a;
  endtask
  task recv(output logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--) slot(1'b1, d[i]);
    slot(1'b0, a);
  endtask
endmodule

// ### verification/i2c_slave_register_port_test.sv
// self-checking bench for the register port
// assumes the host model owns the bus; the register store lives here
`define CHK(n, e, s) begin n_compared++; if ((e) !== (s)) begin n_mismatch++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module i2c_slave_register_port_test import i2c_slave_port_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, scl, moe, oe, sv, stb, own;
  logic [2:0] ka, kb;
  logic [7:0] ix, d, q, ri;
  logic [7:0] regs [256] = '{default: 8'h00};
  logic [6:0] ad;
  reg_write_t wr;
  sel_level_t sel [3] = '{default: 2'b00};
  int n_mismatch, n_compared, n_stb, s0, cyc, lv [3];
  wire sda = (oe ? sv : 1'b1) & !moe; // released wire reads high
  i2c_host_model m (.scl(scl), .oe(moe), .sda(sda));
  i2c_slave_register_port dut (.i_clk(clk), .i_sys_rst(rst), .i_scl(scl), .i_sda(sda),
    .o_sda(sv), .o_sda_oe(oe), .i_addr_sel_msb_pin(sel[2]), .i_addr_sel_mid_pin(sel[1]),
    .i_addr_sel_lsb_pin(sel[0]), .i_rd_data(regs[ri]), .o_rd_index(ri), .o_wr(wr),
    .o_wr_stb(stb));
  always #5 clk = !clk;
  // register store and watchdog
  always @(posedge clk) begin
    cyc++;
    if (stb) begin
      regs[wr.index] <= wr.data;
      n_stb++;
    end
    if (cyc == 60000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  // slave address from the three strap levels, low 0, floating 1, high 2
  function automatic logic [6:0] exp_addr(input int hi, input int mid, input int lo);
    return 7'h08 + 7'(9 * hi + 3 * mid + lo);
  endfunction
  task give_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // pins all low then all high first; every fourth pass is foreign
  initial begin
    void'($urandom(98005));
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    for (int i = 0; i < 8; i++) begin
      repeat (4) @(posedge clk);
      #1 own = i % 4 != 3;
      foreach (lv[k]) lv[k] = i < 2 ? 2 * i : $urandom_range(2);
      foreach (sel[k]) sel[k] = {lv[k] == 2, lv[k] == 1};
      ad = exp_addr(lv[2], lv[1], lv[0]) ^ {!own, 6'h00};
      ix = 8'($urandom);
      d = 8'($urandom);
      s0 = n_stb;
      m.start();
      m.send({ad, 1'b0}, ka[2]);
      m.send(ix, ka[1]);
      m.send(d, ka[0]);
      m.stop();
      m.start();
      m.send({ad, 1'b0}, kb[2]);
      m.send(ix, kb[1]);
      m.start();
      m.send({ad, 1'b1}, kb[0]);
      m.recv(q);
      m.stop();
      `CHK("write acks", {3{own}}, ka)
      `CHK("strobes", s0 + own, n_stb)
      if (own) `CHK("written", {ix, d}, wr)
      if (own) `CHK("index", ix, ri)
      `CHK("read acks", {3{own}}, kb)
      `CHK("read data", own ? d : 8'hff, q)
    end
    give_verdict();
  end
endmodule
